// File: rtl/sbrg_top.sv
// Serial baud rate generator for two async ports and a 3-wire port
`timescale 1ns/1ns
module sbrg_top (
	input wire logic clk,
	input wire logic reset,
	input wire sbrg_pkg::sbrg_ctrl_s baud_divisor_control,
	input wire sbrg_pkg::sbrg_ctrl_s second_baud_divisor_control,
	input wire logic [7:0] async_mode_register,
	input wire logic [7:0] second_async_mode_register,
	input wire logic async_tx_en,
	input wire logic async_rx_en,
	input wire logic second_async_tx_en,
	input wire logic second_async_rx_en,
	input wire logic clocked_serial_io_en,
	input wire logic serial_clock_source_select,
	input wire logic serial_clock_pin_is_output,
	input wire logic external_baud_clock_in,
	input wire logic second_external_baud_clock_in,
	output logic async_baud_clk,
	output logic async_baud_tick,
	output logic second_async_baud_clk,
	output logic second_async_baud_tick,
	output logic serial_clock_out,
	output logic [1:0] generator_running,
	output logic [1:0] prescaler_code_bad
);
	logic half_q;
	logic [1:0] ext_in;
	logic [1:0] ext_prev_q;
	logic [1:0] run;
	logic [1:0] int_sel;
	logic [1:0] active;
	logic [1:0] src_tick;
	logic [1:0] presc_tick;
	logic [1:0] div_tick;
	logic [1:0] bypass;
	logic [1:0] clk_q;
	logic [1:0] tick_q;
	logic [4:0] limit [2];
	sbrg_pkg::sbrg_ctrl_s cfg [2];
	logic csi_run;
	logic uart0_run;

	// ============================================================
	// Run conditions and source selection
	assign uart0_run = async_tx_en || async_rx_en;
	assign csi_run = clocked_serial_io_en && serial_clock_source_select
		&& serial_clock_pin_is_output;
	assign run[0] = uart0_run || csi_run;
	assign run[1] = second_async_tx_en || second_async_rx_en;
	assign int_sel[0] = uart0_run ?
		async_mode_register[sbrg_pkg::ASYNC_SRC_SEL_POS] : 1'b1;
	assign int_sel[1] =
		second_async_mode_register[sbrg_pkg::ASYNC_SRC_SEL_POS];
	assign cfg[0] = baud_divisor_control;
	assign cfg[1] = second_baud_divisor_control;
	assign ext_in = {second_external_baud_clock_in, external_baud_clock_in};

	// ============================================================
	// Internal source at half the host clock
	always_ff @(posedge clk) begin
		if (reset || (active == 2'b00)) begin
			half_q <= 1'b0;
		end else begin
			half_q <= !half_q;
		end
	end

	// Follows the pins through reset as well, so no false edge after it
	always_ff @(posedge clk) begin
		ext_prev_q <= ext_in;
	end

	// ============================================================
	// Per-channel divider chain
	for (genvar c = 0; c < 2; c++) begin : g_chan
		assign active[c] = run[c]
			&& (cfg[c].prescaler_select <= sbrg_pkg::PRESC_MAX);
		assign prescaler_code_bad[c] =
			cfg[c].prescaler_select > sbrg_pkg::PRESC_MAX;
		assign src_tick[c] = int_sel[c] ? half_q
			: (ext_in[c] && !ext_prev_q[c]);
		// External source fixes division at 16
		assign limit[c] = int_sel[c]
			? sbrg_pkg::DIV_BASE_M1 + {1'b0, cfg[c].counter_divisor_select}
			: sbrg_pkg::DIV_BASE_M1;
		assign bypass[c] = int_sel[c] && (cfg[c].counter_divisor_select
			== sbrg_pkg::DIV_HIGH_SPEED);

		sbrg_prescaler u_presc (
			.clk(clk),
			.reset(reset),
			.run(active[c]),
			.src_tick(src_tick[c]),
			.sel(cfg[c].prescaler_select),
			.out_tick(presc_tick[c])
		);

		sbrg_divcount u_div (
			.clk(clk),
			.reset(reset),
			.run(active[c]),
			.in_tick(presc_tick[c]),
			.bypass(bypass[c]),
			.limit(limit[c]),
			.out_tick(div_tick[c])
		);

		// Final divide by two
		always_ff @(posedge clk) begin
			if (reset || !active[c]) begin
				clk_q[c] <= 1'b0;
				tick_q[c] <= 1'b0;
			end else begin
				clk_q[c] <= clk_q[c] ^ div_tick[c];
				tick_q[c] <= div_tick[c] && !clk_q[c];
			end
		end
	end

	// ============================================================
	// Outputs
	assign generator_running = active;
	assign async_baud_clk = clk_q[0] && uart0_run;
	assign async_baud_tick = tick_q[0] && uart0_run;
	assign second_async_baud_clk = clk_q[1];
	assign second_async_baud_tick = tick_q[1];
	assign serial_clock_out = clk_q[0] && csi_run;
endmodule // sbrg_top

// File: pkg/sbrg_pkg.sv
// Constants and types shared by the serial baud rate generator
// ============================================================
// What this block does
// - Prescaler n divides internal 2^(n+2), external 2^(n+1)
// - Generator runs only while serial transfer enabled
// - Source is fxx/2 or external baud pin
// - Source select bit one picks internal clock
// - Internal, k below 15: divide by k+16, then halve
// - Select bit zero picks external; software sets k=0
// - External: prescale, then divide by 16 and 2
// - Serial clock only when selected and pin output
// - 3-wire normal: divide by k+16, then halve
// - 3-wire high speed: bypass counter, only halve
package sbrg_pkg;

	// ============================================================
	// Control byte layout
	localparam int PRESC_POS = 4;
	localparam int DIVSEL_POS = 0;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam int ASYNC_SRC_SEL_POS = 0;

	// ============================================================
	// Divider constants
	localparam logic [3:0] PRESC_MAX = 4'h0b;
	localparam logic [3:0] DIV_HIGH_SPEED = 4'h0f;
	localparam logic [4:0] DIV_BASE_M1 = 5'h0f;
	localparam logic [11:0] PRESC_ONES = 12'h0fff;

	// ============================================================
	// Timing of the host clock
	localparam int CLK_PERIOD_NS = 4;
	localparam int INT_SRC_DIV = 2;
	localparam int INT_SRC_CYCLES = INT_SRC_DIV * CLK_PERIOD_NS / CLK_PERIOD_NS;

	typedef struct packed {
		logic [3:0] prescaler_select;
		logic [3:0] counter_divisor_select;
	} sbrg_ctrl_s;

endpackage

// File: rtl/sbrg_prescaler.sv
// Twelve-bit prescaler with selectable power-of-two tap
`timescale 1ns/1ns
module sbrg_prescaler (
	input wire logic clk,
	input wire logic reset,
	input wire logic run,
	input wire logic src_tick,
	input wire logic [3:0] sel,
	output logic out_tick
);
	logic [11:0] count_q;
	logic [11:0] mask;
	logic hit;

	// ============================================================
	// Tap mask of n+1 ones
	assign mask = sbrg_pkg::PRESC_ONES >> (sbrg_pkg::PRESC_MAX - sel);
	assign hit = src_tick && ((count_q & mask) == mask);

	always_ff @(posedge clk) begin
		if (reset || !run) begin
			count_q <= 12'h0000;
		end else if (src_tick) begin
			count_q <= count_q + 12'h0001;
		end
	end

	always_ff @(posedge clk) begin
		if (reset || !run) begin
			out_tick <= 1'b0;
		end else begin
			out_tick <= hit;
		end
	end
endmodule // sbrg_prescaler

// File: rtl/sbrg_divcount.sv
// Five-bit divide-by-(k+16) counter with bypass
`timescale 1ns/1ns
module sbrg_divcount (
	input wire logic clk,
	input wire logic reset,
	input wire logic run,
	input wire logic in_tick,
	input wire logic bypass,
	input wire logic [4:0] limit,
	output logic out_tick
);
	logic [4:0] count_q;

	always_ff @(posedge clk) begin
		if (reset || !run || bypass) begin
			count_q <= 5'h00;
		end else if (in_tick) begin
			count_q <= (count_q == limit) ? 5'h00 : count_q + 5'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (reset || !run) begin
			out_tick <= 1'b0;
		end else if (bypass) begin
			out_tick <= in_tick;
		end else begin
			out_tick <= in_tick && (count_q == limit);
		end
	end
endmodule // sbrg_divcount

// File: sim/sbrg_ext_src.sv
// External baud clock source model
`timescale 1ns/1ns
module sbrg_ext_src #(parameter int HALF = 4) (
	input wire logic clk,
	output logic ext
);
	// ============================================================
	// Free-running square wave, no faster than fxx/4
	int c = 0;
	initial ext = 1'b0;
	always @(posedge clk) begin
		c <= (c == HALF - 1) ? 0 : c + 1;
		if (c == HALF - 1) ext <= ~ext;
	end
endmodule // sbrg_ext_src

// File: sim/sbrg_sva.sv
// Port checker for the baud rate generator
`timescale 1ns/1ns
module sbrg_sva (
	input wire logic clk,
	input wire logic reset,
	input wire sbrg_pkg::sbrg_ctrl_s baud_divisor_control,
	input wire logic async_tx_en,
	input wire logic async_rx_en,
	input wire logic clocked_serial_io_en,
	input wire logic serial_clock_source_select,
	input wire logic serial_clock_pin_is_output,
	input wire logic async_baud_clk,
	input wire logic async_baud_tick,
	input wire logic serial_clock_out,
	input wire logic [1:0] generator_running,
	input wire logic [1:0] prescaler_code_bad
);
	// ============================================================
	// Relations between ports
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	wire logic a_on = async_tx_en | async_rx_en;
	wire logic s_on = clocked_serial_io_en & serial_clock_source_select
		& serial_clock_pin_is_output;
	sequence a_off_s; !a_on [*4]; endsequence
	sequence s_off_s; !s_on [*4]; endsequence
	a_bad_code: assert property (prescaler_code_bad[0] ==
		(baud_divisor_control.prescaler_select > sbrg_pkg::PRESC_MAX))
		else $error("bad code flag wrong");
	a_bad_idle: assert property (prescaler_code_bad[1] |->
		!generator_running[1]) else $error("bad code channel runs");
	a_async_idle: assert property (a_off_s |->
		!async_baud_clk && !async_baud_tick) else $error("async not idle");
	a_sck_idle: assert property (s_off_s |-> !serial_clock_out)
		else $error("serial clock without select");
	a_run_cause: assert property (generator_running[0] |-> a_on ||
		clocked_serial_io_en || $past(a_on || clocked_serial_io_en))
		else $error("running while disabled");
	a_tick_single: assert property (async_baud_tick |=>
		!async_baud_tick) else $error("tick too long");
	a_bad_quiet: assert property (prescaler_code_bad[0] [*4] |->
		!async_baud_tick) else $error("tick with bad code");
	a_sck_hold: assert property ($rose(serial_clock_out) |=>
		(serial_clock_out || !s_on) [*7]) else $error("serial clock fast");
endmodule // sbrg_sva
bind sbrg_top sbrg_sva sbrg_sva_inst (.clk(clk), .reset(reset),
	.baud_divisor_control(baud_divisor_control),
	.async_tx_en(async_tx_en), .async_rx_en(async_rx_en),
	.clocked_serial_io_en(clocked_serial_io_en),
	.serial_clock_source_select(serial_clock_source_select),
	.serial_clock_pin_is_output(serial_clock_pin_is_output),
	.async_baud_clk(async_baud_clk), .async_baud_tick(async_baud_tick),
	.serial_clock_out(serial_clock_out),
	.generator_running(generator_running),
	.prescaler_code_bad(prescaler_code_bad));

// File: sim/sbrg_top_tb.sv
// Self-checking bench for the baud rate generator
`timescale 1ns/1ns
module sbrg_top_tb;
	logic clk = 1'b0;
	logic reset = 1'b1;
	sbrg_pkg::sbrg_ctrl_s c0 = '0;
	sbrg_pkg::sbrg_ctrl_s c1 = '0;
	logic [7:0] m = '0;
	logic [6:0] en = '0;
	logic ext, t0, t1, sco, sco_q, k0, k1;
	logic [1:0] run_w, bad_w;
	int err_count = 0;
	int checked = 0;
	int cyc = 0;
	initial forever #2 clk = ~clk;
	sbrg_ext_src #(.HALF(4)) sbrg_ext_src_inst (.clk(clk), .ext(ext));
	sbrg_top sbrg_top_inst (.clk(clk), .reset(reset),
		.baud_divisor_control(c0), .second_baud_divisor_control(c1),
		.async_mode_register(m), .second_async_mode_register(m),
		.async_tx_en(en[6]), .async_rx_en(en[5]),
		.second_async_tx_en(en[4]), .second_async_rx_en(en[3]),
		.clocked_serial_io_en(en[2]), .serial_clock_source_select(en[1]),
		.serial_clock_pin_is_output(en[0]), .external_baud_clock_in(ext),
		.second_external_baud_clock_in(ext),
		.async_baud_clk(k0), .async_baud_tick(t0),
		.second_async_baud_clk(k1),
		.second_async_baud_tick(t1), .serial_clock_out(sco),
		.generator_running(run_w), .prescaler_code_bad(bad_w));
	// ============================================================
	// Timeout, compare and access tasks
	always @(posedge clk) begin
		sco_q <= sco;
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			results();
		end
	end
	task automatic chk(string s, logic [31:0] e, logic [31:0] g);
		checked++;
		if (g !== e) begin
			err_count++;
			$display("BAD %s exp %0d got %0d", s, e, g);
		end
	endtask
	task automatic go(logic [7:0] a, logic [7:0] b, logic [7:0] md,
		logic [6:0] e);
		@(posedge clk);
		en <= '0;
		repeat (4) @(posedge clk);
		c0 <= a;
		c1 <= b;
		m <= md;
		en <= e;
	endtask
	task automatic per(int s, logic [31:0] e);
		int c;
		int n;
		int h;
		logic v;
		logic lv;
		c = 0;
		n = 0;
		h = 0;
		while (n < 2 && c < 3000) begin
			@(posedge clk);
			#1;
			c++;
			v = (s == 0) ? t0 : (s == 1) ? t1 : sco & ~sco_q;
			lv = (s == 0) ? k0 : (s == 1) ? k1 : sco;
			if (n == 1 && lv === 1'b1 && !v) h++;
			if (v) begin
				n++;
				if (n == 1) begin
					c = 0;
					h = (lv === 1'b1) ? 1 : 0;
				end
			end
		end
		chk("period", e, c);
		chk("high", e / 2, h);
		$display("test on output %0d done", s);
	endtask
	task results;
		$display("checked %0d err_count %0d", checked, err_count);
		if (err_count == 0 && checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		#1;
		chk("running", 0, run_w);
		go(8'h00, 8'h00, 8'h01, 7'h40);
		per(0, 128);
		chk("running", 1, run_w);
		go(8'h11, 8'h00, 8'h01, 7'h20);
		per(0, 272);
		go(8'h1f, 8'h00, 8'h00, 7'h07);
		per(2, 16);
		go(8'h02, 8'h00, 8'h00, 7'h07);
		per(2, 144);
		go(8'hc0, 8'hd0, 8'h01, 7'h50);
		repeat (4) @(posedge clk);
		#1;
		chk("bad", 2'b11, bad_w);
		chk("running", 0, run_w);
		$display("test on bad codes done");
		go(8'h10, 8'h00, 8'h00, 7'h40);
		per(0, 1024);
		go(8'h00, 8'h21, 8'h01, 7'h08);
		per(1, 544);
		go(8'h00, 8'h00, 8'h00, 7'h10);
		per(1, 512);
		chk("running", 2, run_w);
		results();
	end
endmodule // sbrg_top_tb
